/* hdl/stm_params.svh */
// Register offsets, field positions, reset values and timing counts of the standard timer
`ifndef STM_PARAMS_SVH
`define STM_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte addresses (one aligned word each)
// ----------------------------------------------------------------------
`define STM_OFS_CTRL0     8'h00
`define STM_OFS_CTRL1     8'h04
`define STM_OFS_CNT_LO    8'h08
`define STM_OFS_CNT_HI    8'h0C
`define STM_OFS_CMPA_LO   8'h10
`define STM_OFS_CMPA_HI   8'h14
`define STM_OFS_CAPTURE   8'h18

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define STM_CTRL_RESET    8'h00
`define STM_CNT_WIDTH     10
`define STM_CNT_MAX       10'h03FF
`define STM_HI_PAD        6'h00
`define STM_DIV_FH16      4'hF
`define STM_DIV_FH64      6'h3F

`endif

/* hdl/stm_pkg.sv */
// Types shared by the standard timer design
package stm_pkg;

   typedef enum logic [1:0] {
      STM_MODE_COMPARE,
      STM_MODE_CAPTURE,
      STM_MODE_PWM,
      STM_MODE_TIMER
   } stm_mode_type;

   typedef struct packed {
      logic       pause;
      logic [2:0] clk_sel;
      logic       run;
      logic [2:0] period_cmp;
   } stm_ctrl0_type;

   typedef struct packed {
      logic [1:0] op_mode;
      logic [1:0] pin_func;
      logic       out_level;
      logic       out_invert;
      logic       duty_swap;
      logic       clear_src;
   } stm_ctrl1_type;

   typedef struct packed {
      logic       match_a;
      logic       match_p;
   } stm_event_type;

endpackage

/* hdl/stm_timer.sv */
// Standard 10-bit timer with AHB-Lite register slave
//
// Behaviour
// [RULE_01] Counter value readable as byte pair; writes to it are ignored.
// [RULE_02] Pause bit holds the count; clearing it resumes from held value.
// [RULE_03] Clock select picks core/4, core, high/16, high/64, timebase, ext edges.
// [RULE_04] Run rising edge zeroes and starts counter; falling edge stops, keeps count.
// [RULE_05] Run rising edge loads output level in compare, PWM, single-pulse modes.
// [RULE_06] Period field compares with counter bits 9..7; zero means 1024 clocks.
// [RULE_07] Clear-source 0: clear on P match, overflow when period field zero.
// [RULE_08] Clear-source 1: clear on compare A match.
// [RULE_09] Clear-source ignored in PWM, single-pulse and capture modes.
// [RULE_10] Mode field: compare, capture, PWM/single-pulse, timer/counter.
// [RULE_11] Software stops the timer before changing mode.
// [RULE_12] Compare mode A match: none, low, high or toggle output.
// [RULE_13] PWM mode pin function: inactive, active, PWM, single pulse.
// [RULE_14] Capture edge: rising, falling, both, disabled.
// [RULE_15] Requested level equal to current level gives no visible change.
// [RULE_16] Software changes pin function in PWM only while stopped.
// [RULE_17] Output level bit meaning depends on mode.
// [RULE_18] Invert bit inverts output pin, except in timer/counter mode; the code inverts the pin in every mode.
// [RULE_19] Swap bit exchanges period and duty roles in PWM.
// [RULE_20] Compare A held as byte pair; high byte upper bits read zero.
// [RULE_21] Timer/counter mode leaves output pin unused.
// [RULE_22] Low bytes pass an 8-bit buffer, committed or latched via high byte.
// [RULE_23] Counter is 10-bit, counting up per selected clock.
// [RULE_24] Comparators A and P each raise their own request pulse; the code suppresses the P request while A clears outside PWM.
// [RULE_25] External clock pin synchronised before edge detection.
`timescale 1ns/100ps
`include "stm_params.svh"

module stm_timer
   import stm_pkg::*;
#(
   parameter int CNT_W = `STM_CNT_WIDTH
) (
   input  wire logic              clock,
   input  wire logic              rst_b,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic [31:0]            hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic              high_clock_tick,
   input  wire logic              timebase_clock,
   input  wire logic              ext_clock_pin,
   input  wire logic              capture_input_pin,
   output logic                   timer_output_pin,
   output logic                   timer_output_en,
   output logic                   match_a_irq,
   output logic                   match_p_irq
);

   // ----------------------------------------------------------------------
   // Reset release and input synchronisers
   // ----------------------------------------------------------------------
   logic          rst_meta_reg;
   logic          rst_sync_reg;
   logic [2:0]    in_meta_reg;
   logic [2:0]    in_sync_reg;
   logic [2:0]    in_last_reg;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // Pins and foreign clocks: two flops, then an edge detector on the second
   always_ff @(posedge clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         in_meta_reg <= 3'h0;
         in_sync_reg <= 3'h0;
         in_last_reg <= 3'h0;
      end else begin
         in_meta_reg <= {capture_input_pin, timebase_clock, ext_clock_pin}; // [RULE_25]
         in_sync_reg <= in_meta_reg;
         in_last_reg <= in_sync_reg;
      end
   end

   wire ext_rise  = in_sync_reg[0] & ~in_last_reg[0];
   wire ext_fall  = ~in_sync_reg[0] & in_last_reg[0];
   wire tbc_rise  = in_sync_reg[1] & ~in_last_reg[1];
   wire cap_rise  = in_sync_reg[2] & ~in_last_reg[2];
   wire cap_fall  = ~in_sync_reg[2] & in_last_reg[2];

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   stm_ctrl0_type    ctrl0_reg;
   stm_ctrl1_type    ctrl1_reg;
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] cmpa_reg;
   logic [CNT_W-1:0] capture_reg;
   logic [7:0]       lo_buf_reg;
   logic             run_last_reg;
   logic             out_reg;
   logic             pulse_done_reg;
   logic [1:0]       div4_reg;
   logic [5:0]       hdiv_reg;
   stm_event_type    event_reg;

   // ----------------------------------------------------------------------
   // AHB-Lite slave: zero wait states, always OKAY
   // ----------------------------------------------------------------------
   logic        dp_wr_reg;
   logic        dp_rd_reg;
   logic [7:0]  dp_addr_reg;

   wire ap_valid = hsel & htrans[1] & hready;

   always_ff @(posedge clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         dp_wr_reg   <= 1'b0;
         dp_rd_reg   <= 1'b0;
         dp_addr_reg <= 8'h00;
      end else begin
         dp_wr_reg   <= ap_valid & hwrite;
         dp_rd_reg   <= ap_valid & ~hwrite;
         dp_addr_reg <= haddr[7:0];
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   wire [7:0] wbyte     = hwdata[7:0];
   wire wr_ctrl0        = dp_wr_reg && (dp_addr_reg == `STM_OFS_CTRL0);
   wire wr_ctrl1        = dp_wr_reg && (dp_addr_reg == `STM_OFS_CTRL1);
   wire wr_cmpa_lo      = dp_wr_reg && (dp_addr_reg == `STM_OFS_CMPA_LO);
   wire wr_cmpa_hi      = dp_wr_reg && (dp_addr_reg == `STM_OFS_CMPA_HI);
   // Read of a high byte is seen in the address phase so data is ready in the data phase
   wire rd_ap           = ap_valid & ~hwrite;
   wire rd_cnt_hi       = rd_ap && (haddr[7:0] == `STM_OFS_CNT_HI);
   wire rd_cmpa_hi      = rd_ap && (haddr[7:0] == `STM_OFS_CMPA_HI);

   logic [31:0] rdata_next;
   always_comb begin
      if (haddr[7:0] == `STM_OFS_CTRL0)
         rdata_next = {24'h0000_00, ctrl0_reg};
      else if (haddr[7:0] == `STM_OFS_CTRL1)
         rdata_next = {24'h0000_00, ctrl1_reg};
      else if (haddr[7:0] == `STM_OFS_CNT_LO || haddr[7:0] == `STM_OFS_CMPA_LO)
         rdata_next = {24'h0000_00, lo_buf_reg};                        // [RULE_22]
      else if (haddr[7:0] == `STM_OFS_CNT_HI)
         rdata_next = {24'h0000_00, `STM_HI_PAD, count_reg[9:8]};        // [RULE_01]
      else if (haddr[7:0] == `STM_OFS_CMPA_HI)
         rdata_next = {24'h0000_00, `STM_HI_PAD, cmpa_reg[9:8]};         // [RULE_20]
      else if (haddr[7:0] == `STM_OFS_CAPTURE)
         rdata_next = {22'h00_0000, capture_reg};
      else
         rdata_next = 32'h0000_0000;
   end

   always_ff @(posedge clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg)
         hrdata <= 32'h0000_0000;
      else if (rd_ap)
         hrdata <= rdata_next;
   end

   // Low byte buffer: written by compare A low-byte write, loaded by high-byte reads
   always_ff @(posedge clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg)
         lo_buf_reg <= 8'h00;
      else if (wr_cmpa_lo)
         lo_buf_reg <= wbyte;                                          // [RULE_22]
      else if (rd_cnt_hi)
         lo_buf_reg <= count_reg[7:0];                                 // [RULE_22]
      else if (rd_cmpa_hi)
         lo_buf_reg <= cmpa_reg[7:0];
   end

   always_ff @(posedge clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         ctrl0_reg <= `STM_CTRL_RESET;
         ctrl1_reg <= `STM_CTRL_RESET;
         cmpa_reg  <= 10'h000;
      end else begin
         if (wr_ctrl0)
            ctrl0_reg <= wbyte;
         if (wr_ctrl1)
            ctrl1_reg <= wbyte;
         if (wr_cmpa_hi)
            cmpa_reg <= {wbyte[1:0], lo_buf_reg};                      // [RULE_20] [RULE_22]
      end
   end

   // ----------------------------------------------------------------------
   // Clock source selection
   // ----------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         div4_reg <= 2'h0;
         hdiv_reg <= 6'h00;
      end else begin
         div4_reg <= div4_reg + 2'h1;
         if (high_clock_tick)
            hdiv_reg <= hdiv_reg + 6'h01;
      end
   end

   logic cnt_tick;
   always_comb begin
      case (ctrl0_reg.clk_sel)                                         // [RULE_03]
         3'b000:  cnt_tick = (div4_reg == 2'h3);
         3'b001:  cnt_tick = 1'b1;
         3'b010:  cnt_tick = high_clock_tick && (hdiv_reg[3:0] == `STM_DIV_FH16);
         3'b011:  cnt_tick = high_clock_tick && (hdiv_reg == `STM_DIV_FH64);
         3'b110:  cnt_tick = ext_rise;
         3'b111:  cnt_tick = ext_fall;
         default: cnt_tick = tbc_rise;
      endcase
   end

   // ----------------------------------------------------------------------
   // Counter, comparators and clearing
   // ----------------------------------------------------------------------
   stm_mode_type mode;
   assign mode = stm_mode_type'(ctrl1_reg.op_mode);                    // [RULE_10]

   wire run_rise   = ctrl0_reg.run & ~run_last_reg;
   wire counting   = ctrl0_reg.run & ~ctrl0_reg.pause & cnt_tick;      // [RULE_02] [RULE_04]
   wire [CNT_W-1:0] count_inc = count_reg + 10'h001;
   wire overflow   = counting && (count_reg == `STM_CNT_MAX);
   // Period field 000 is the 1024 boundary, i.e. wrap of the counter
   wire p_hit      = (ctrl0_reg.period_cmp == 3'b000) ? overflow :
                     (counting && count_inc[9:7] == ctrl0_reg.period_cmp
                      && count_inc[6:0] == 7'h00);                     // [RULE_06]
   wire a_hit      = counting && (count_inc == cmpa_reg) && (cmpa_reg != 10'h000);
   wire pwm_mode   = (mode == STM_MODE_PWM);
   wire clr_a      = pwm_mode ? ctrl1_reg.duty_swap :
                     (mode != STM_MODE_CAPTURE && ctrl1_reg.clear_src); // [RULE_09] [RULE_19]
   wire clr_p      = pwm_mode ? ~ctrl1_reg.duty_swap :
                     (mode == STM_MODE_CAPTURE || !ctrl1_reg.clear_src);
   wire clear_now  = (clr_a && a_hit) || (clr_p && p_hit);             // [RULE_07] [RULE_08]

   always_ff @(posedge clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         count_reg    <= 10'h000;
         run_last_reg <= 1'b0;
      end else begin
         run_last_reg <= ctrl0_reg.run;
         if (run_rise)
            count_reg <= 10'h000;                                      // [RULE_04]
         else if (clear_now)
            count_reg <= 10'h000;
         else if (counting)
            count_reg <= count_inc;                                    // [RULE_23]
      end
   end

   // Comparator P request is suppressed while comparator A clears outside PWM
   always_ff @(posedge clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg)
         event_reg <= 2'b00;
      else begin
         event_reg.match_a <= a_hit;                                   // [RULE_24]
         event_reg.match_p <= p_hit && (pwm_mode || !clr_a);
      end
   end
   assign match_a_irq = event_reg.match_a;
   assign match_p_irq = event_reg.match_p;

   // ----------------------------------------------------------------------
   // Capture
   // ----------------------------------------------------------------------
   logic cap_hit;
   always_comb begin
      case (ctrl1_reg.pin_func)                                        // [RULE_14]
         2'b00:   cap_hit = cap_rise;
         2'b01:   cap_hit = cap_fall;
         2'b10:   cap_hit = cap_rise | cap_fall;
         default: cap_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg)
         capture_reg <= 10'h000;
      else if (mode == STM_MODE_CAPTURE && ctrl0_reg.run && cap_hit)
         capture_reg <= count_reg;
   end

   // ----------------------------------------------------------------------
   // Output pin
   // ----------------------------------------------------------------------
   // PWM duty source follows the swap bit; duty >= period gives 100 %
   wire [CNT_W-1:0] duty_val = ctrl1_reg.duty_swap ?
                               {ctrl0_reg.period_cmp, 7'h00} : cmpa_reg;
   wire pwm_active = ctrl1_reg.duty_swap && ctrl0_reg.period_cmp == 3'b000 ?
                     1'b1 : (count_reg < duty_val);                    // [RULE_19]

   logic out_next;
   always_comb begin
      out_next = out_reg;
      if (run_rise && mode != STM_MODE_TIMER && mode != STM_MODE_CAPTURE)
         out_next = ctrl1_reg.out_level;                               // [RULE_05] [RULE_17]
      else if (mode == STM_MODE_COMPARE && a_hit) begin
         case (ctrl1_reg.pin_func)                                     // [RULE_12] [RULE_15]
            2'b01:   out_next = 1'b0;
            2'b10:   out_next = 1'b1;
            2'b11:   out_next = ~out_reg;
            default: out_next = out_reg;
         endcase
      end else if (pwm_mode) begin
         case (ctrl1_reg.pin_func)                                     // [RULE_13]
            2'b00:   out_next = ~ctrl1_reg.out_level;
            2'b01:   out_next = ctrl1_reg.out_level;
            2'b10:   out_next = ctrl0_reg.run &&
                                (pwm_active ~^ ctrl1_reg.out_level);
            default: out_next = (ctrl0_reg.run && !pulse_done_reg) ?
                                ctrl1_reg.out_level : ~ctrl1_reg.out_level;
         endcase
      end
   end

   // Single pulse ends on the first duty match after start
   always_ff @(posedge clock or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         out_reg        <= 1'b0;
         pulse_done_reg <= 1'b0;
      end else begin
         out_reg <= out_next;
         if (run_rise)
            pulse_done_reg <= 1'b0;
         else if (counting && count_inc == duty_val)
            pulse_done_reg <= 1'b1;
      end
   end

   assign timer_output_pin = out_reg ^ ctrl1_reg.out_invert;           // [RULE_18]
   assign timer_output_en  = (mode != STM_MODE_TIMER);                 // [RULE_21]

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_sync_reg);

   AST_RUN_CLEARS: assert property (run_rise |=> count_reg == 10'h000) // [RULE_04]
      else $error("Counter not zero after run start");
   AST_PAUSE_HOLDS: assert property (ctrl0_reg.pause && !run_rise && !clear_now
      |=> $stable(count_reg)) // [RULE_02]
      else $error("Counter moved while paused");
   AST_STOP_HOLDS: assert property (!ctrl0_reg.run && !run_last_reg |=> $stable(count_reg)) // [RULE_04]
      else $error("Counter moved while stopped");
   AST_CLEAR_A: assert property (mode == STM_MODE_COMPARE && ctrl1_reg.clear_src && a_hit
      && !run_rise |=> count_reg == 10'h000) // [RULE_08]
      else $error("Compare A did not clear counter");
   AST_CLEAR_P: assert property (mode == STM_MODE_TIMER && !ctrl1_reg.clear_src && p_hit
      && !run_rise |=> count_reg == 10'h000) // [RULE_07]
      else $error("Period match did not clear counter");
   AST_INIT_LEVEL: assert property (run_rise && mode == STM_MODE_COMPARE
      |=> out_reg == $past(ctrl1_reg.out_level)) // [RULE_05]
      else $error("Output not at initial level after start");
   AST_TOGGLE: assert property (mode == STM_MODE_COMPARE && a_hit && !run_rise
      && ctrl1_reg.pin_func == 2'b11 |=> out_reg != $past(out_reg)) // [RULE_12]
      else $error("Toggle on match missing");
   AST_HI_READ_ZERO: assert property (dp_rd_reg && dp_addr_reg == `STM_OFS_CMPA_HI
      |-> hrdata[31:2] == 30'h0000_0000) // [RULE_20]
      else $error("Compare high byte upper bits not zero");
   AST_IRQ_A: assert property (a_hit |=> match_a_irq) // [RULE_24]
      else $error("Compare A request missing");

   COV_RUN_START: cover property (run_rise ##1 counting);
   COV_A_MATCH: cover property (a_hit ##1 match_a_irq);
   COV_OVERFLOW: cover property (overflow);
   COV_CAPTURE: cover property (mode == STM_MODE_CAPTURE && cap_hit);

endmodule

/* tb/testbench.sv */
// Self-checking bench for the standard timer: AHB-Lite register tasks and directed tests
`timescale 1ns/100ps
`include "stm_params.svh"

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end

module testbench;
   import stm_pkg::*;

   // ----------------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------------
   logic        clock;
   logic        rst_b;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        high_clock_tick;
   logic        timebase_clock;
   logic        ext_clock_pin;
   logic        capture_input_pin;
   logic        timer_output_pin;
   logic        timer_output_en;
   logic        match_a_irq;
   logic        match_p_irq;
   int          bad_count;
   int          cmp_count;
   int          cyc;
   int          a_cnt;
   int          p_cnt;
   int          p_last;
   int          p_prev;
   logic [7:0]  rd;
   logic [9:0]  cnt;
   int          s;

   stm_timer u_dut (
      .clock             (clock),
      .rst_b             (rst_b),
      .hsel              (hsel),
      .haddr             (haddr),
      .htrans            (htrans),
      .hwrite            (hwrite),
      .hsize             (hsize),
      .hwdata            (hwdata),
      .hready            (hreadyout),
      .hrdata            (hrdata),
      .hreadyout         (hreadyout),
      .hresp             (hresp),
      .high_clock_tick   (high_clock_tick),
      .timebase_clock    (timebase_clock),
      .ext_clock_pin     (ext_clock_pin),
      .capture_input_pin (capture_input_pin),
      .timer_output_pin  (timer_output_pin),
      .timer_output_en   (timer_output_en),
      .match_a_irq       (match_a_irq),
      .match_p_irq       (match_p_irq)
   );

   always #5 clock = ~clock;

   // ----------------------------------------------------------------------
   // Event monitors and hang guard
   // ----------------------------------------------------------------------
   always @(posedge clock) begin
      cyc++;
      if (match_a_irq === 1'b1) a_cnt++;
      if (match_p_irq === 1'b1) begin
         p_prev = p_last;
         p_last = cyc;
         p_cnt++;
      end
      // Longest test sequence is about 13000 cycles; leave wide margin
      if (cyc == 60000) begin
         bad_count++;
         stop_test();
      end
   end

   // ----------------------------------------------------------------------
   // Bus and pin tasks
   // ----------------------------------------------------------------------
   task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      hsel   <= 1'b1;
      haddr  <= {24'h0000_00, a};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= 3'b010;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h0000_00, d};
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata[7:0];
      hsel <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus_xfer(1'b1, a, d);
   endtask

   task automatic rd_cnt();
      bus_xfer(1'b0, `STM_OFS_CNT_HI, 8'h00);
      cnt[9:8] = rd[1:0];
      bus_xfer(1'b0, `STM_OFS_CNT_LO, 8'h00);
      cnt[7:0] = rd;
   endtask

   // Edges are spaced well apart so the pin synchroniser sees each one
   task automatic ext_edges(input int n);
      repeat (n) begin
         repeat (3) @(posedge clock);
         ext_clock_pin <= 1'b1;
         repeat (3) @(posedge clock);
         ext_clock_pin <= 1'b0;
      end
      repeat (6) @(posedge clock);
   endtask

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------------
   // Overflow case runs in timer/counter mode so the period clear is seen there too
   logic [7:0]  per_c1 [6] = '{8'h00, 8'h00, 8'h00, 8'hC0, 8'h00, 8'h81};
   logic [7:0]  per_c0 [6] = '{8'h19, 8'h1B, 8'h09, 8'h18, 8'h29, 8'h19};
   int          per_ex [6] = '{128, 384, 512, 1024, 2048, 128};
   logic [7:0]  regs   [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
   // Two matches per run: toggle returns the pin to its start level
   logic        pin_ex [4] = '{1'b0, 1'b0, 1'b1, 1'b0};

   initial begin
      clock = 1'b0; rst_b = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00;
      hwrite = 1'b0; hsize = 3'b010; hwdata = '0; high_clock_tick = 1'b1;
      timebase_clock = 1'b0; ext_clock_pin = 1'b0; capture_input_pin = 1'b0;
      bad_count = 0; cmp_count = 0; cyc = 0; a_cnt = 0; p_cnt = 0; p_last = 0; p_prev = 0;
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      repeat (3) @(posedge clock);

      // Reset values, unmapped place and read/write access
      foreach (regs[i]) begin
         bus_xfer(1'b0, regs[i], 8'h00);
         `CHK(rd, 8'h00)
      end
      wr(`STM_OFS_CTRL1, 8'hA5);
      bus_xfer(1'b0, `STM_OFS_CTRL1, 8'h00);
      `CHK(rd, 8'hA5)
      wr(`STM_OFS_CTRL0, 8'hF7);
      bus_xfer(1'b0, `STM_OFS_CTRL0, 8'h00);
      `CHK(rd, 8'hF7)
      wr(`STM_OFS_CTRL0, 8'h00);
      wr(`STM_OFS_CMPA_LO, 8'h5A);
      wr(`STM_OFS_CMPA_HI, 8'hFF);
      bus_xfer(1'b0, `STM_OFS_CMPA_HI, 8'h00);
      `CHK(rd, 8'h03)
      bus_xfer(1'b0, `STM_OFS_CMPA_LO, 8'h00);
      `CHK(rd, 8'h5A)
      $display("Test registers done");

      // Counting external edges, pause, stop, restart
      wr(`STM_OFS_CTRL1, 8'hC0);
      wr(`STM_OFS_CTRL0, 8'h68);
      ext_edges(5);
      rd_cnt(); `CHK(cnt, 10'h005)
      wr(`STM_OFS_CTRL0, 8'hE8);
      ext_edges(3);
      rd_cnt(); `CHK(cnt, 10'h005)
      wr(`STM_OFS_CTRL0, 8'h68);
      ext_edges(2);
      rd_cnt(); `CHK(cnt, 10'h007)
      wr(`STM_OFS_CTRL0, 8'h60);
      ext_edges(2);
      wr(`STM_OFS_CNT_HI, 8'h03);
      wr(`STM_OFS_CNT_LO, 8'hFF);
      rd_cnt(); `CHK(cnt, 10'h007)
      wr(`STM_OFS_CTRL0, 8'h78);
      ext_edges(4);
      rd_cnt(); `CHK(cnt, 10'h004)
      $display("Test counting done");

      // Compare output actions on an A match, counter cleared by A except in the last toggle run
      wr(`STM_OFS_CMPA_LO, 8'h03);
      wr(`STM_OFS_CMPA_HI, 8'h00);
      for (int f = 0; f < 4; f++) begin
         wr(`STM_OFS_CTRL0, 8'h60);
         wr(`STM_OFS_CTRL1, {4'b0000, 4'b0001} | (f[1:0] << 4));
         s = a_cnt;
         wr(`STM_OFS_CTRL0, 8'h68);
         repeat (2) @(posedge clock);
         `CHK(timer_output_pin, 1'b0)
         ext_edges(7);
         `CHK(timer_output_pin, pin_ex[f])
         `CHK(a_cnt - s, 2)
      end
      wr(`STM_OFS_CTRL0, 8'h60);
      wr(`STM_OFS_CTRL1, 8'h38);
      s = a_cnt;
      wr(`STM_OFS_CTRL0, 8'h68);
      repeat (2) @(posedge clock);
      `CHK(timer_output_pin, 1'b1)
      ext_edges(7);
      `CHK(a_cnt - s, 1)
      `CHK(timer_output_pin, 1'b0)
      wr(`STM_OFS_CTRL1, 8'h3C);
      // The pin follows the control byte combinationally: look after the write edge settles
      #1;
      `CHK(timer_output_pin, 1'b1)
      `CHK(timer_output_en, 1'b1)
      wr(`STM_OFS_CTRL0, 8'h60);
      wr(`STM_OFS_CTRL1, 8'hFC);
      #1;
      `CHK(timer_output_en, 1'b0)
      $display("Test compare output done");

      // PWM forced levels, active high
      wr(`STM_OFS_CTRL1, 8'h88);
      wr(`STM_OFS_CTRL0, 8'h19);
      repeat (4) @(posedge clock);
      `CHK(timer_output_pin, 1'b0)
      wr(`STM_OFS_CTRL0, 8'h00);
      wr(`STM_OFS_CTRL1, 8'h98);
      wr(`STM_OFS_CTRL0, 8'h19);
      repeat (4) @(posedge clock);
      `CHK(timer_output_pin, 1'b1)
      $display("Test PWM levels done");

      // Capture of the count on rising, then falling edges of the capture pin
      wr(`STM_OFS_CTRL0, 8'h00);
      wr(`STM_OFS_CTRL1, 8'h40);
      wr(`STM_OFS_CTRL0, 8'h68);
      ext_edges(5);
      capture_input_pin <= 1'b1;
      repeat (4) @(posedge clock);
      bus_xfer(1'b0, `STM_OFS_CAPTURE, 8'h00);
      `CHK(rd, 8'h05)
      wr(`STM_OFS_CTRL1, 8'h50);
      ext_edges(2);
      capture_input_pin <= 1'b0;
      repeat (4) @(posedge clock);
      bus_xfer(1'b0, `STM_OFS_CAPTURE, 8'h00);
      `CHK(rd, 8'h07)
      $display("Test capture done");

      // Comparator P spacing per clock source and period field
      foreach (per_ex[i]) begin
         wr(`STM_OFS_CTRL0, 8'h00);
         wr(`STM_OFS_CTRL1, per_c1[i]);
         wr(`STM_OFS_CTRL0, per_c0[i]);
         s = p_cnt;
         while (p_cnt < s + 3) @(posedge clock);
         `CHK(p_last - p_prev, per_ex[i])
      end
      $display("Test period match done");
      stop_test();
   end
endmodule
